/* shared/wire_link_pkg.sv */
// Shared constants, timing and CRC helpers of the single-wire link.
// Assumes a 10 MHz clock on both ends; all times are held in ns.
package wire_link_pkg;

   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned CNT_W         = 13;
   typedef logic [CNT_W-1:0] cnt_t;

   // Least time rounded up to whole cycles, never below one
   function automatic cnt_t cyc_min(input int unsigned ns);
      int unsigned c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return cnt_t'((c == 0) ? 1 : c);
   endfunction : cyc_min

   // Speed dependent pick of a cycle count
   function automatic cnt_t by_speed(input logic fast, input cnt_t reg_v, input cnt_t fast_v);
      return fast ? fast_v : reg_v;
   endfunction : by_speed

   // Reset low time as detected by the device and driven by the master, then master recovery
   localparam int unsigned RESET_LOW_TIME_REG_NS    = 480_000;
   localparam int unsigned RESET_LOW_TIME_FAST_NS   = 48_000;
   localparam int unsigned HOST_RESET_LOW_REG_NS    = 500_000;
   localparam int unsigned HOST_RESET_LOW_FAST_NS   = 60_000;
   localparam int unsigned RECOVERY_TIME_REG_NS     = 480_000;
   localparam int unsigned RECOVERY_TIME_FAST_NS    = 48_000;
   // Presence answer of the device
   localparam int unsigned PRESENCE_WAIT_TIME_REG_NS  = 30_000;
   localparam int unsigned PRESENCE_WAIT_TIME_FAST_NS = 3_000;
   localparam int unsigned PRESENCE_LOW_TIME_REG_NS   = 120_000;
   localparam int unsigned PRESENCE_LOW_TIME_FAST_NS  = 12_000;
   localparam int unsigned PRESENCE_SAMPLE_REG_NS     = 70_000;
   localparam int unsigned PRESENCE_SAMPLE_FAST_NS    = 7_000;
   // Slot timing
   localparam int unsigned SLOT_DELAY_REG_NS  = 30_000;
   localparam int unsigned SLOT_DELAY_FAST_NS = 3_000;
   localparam int unsigned WRITE1_LOW_REG_NS  = 6_000;
   localparam int unsigned WRITE1_LOW_FAST_NS = 1_000;
   localparam int unsigned WRITE0_LOW_REG_NS  = 60_000;
   localparam int unsigned WRITE0_LOW_FAST_NS = 8_000;
   localparam int unsigned READ_LOW_REG_NS    = 2_000;
   localparam int unsigned READ_LOW_FAST_NS   = 1_000;
   localparam int unsigned READ_SAMPLE_REG_NS = 13_000;
   localparam int unsigned READ_SAMPLE_FAST_NS = 1_500;
   localparam int unsigned SLOT_TIME_REG_NS   = 70_000;
   localparam int unsigned SLOT_TIME_FAST_NS  = 10_000;

   localparam cnt_t RST_REG_CYC       = cyc_min(RESET_LOW_TIME_REG_NS);
   localparam cnt_t RST_FAST_CYC      = cyc_min(RESET_LOW_TIME_FAST_NS);
   localparam cnt_t HOST_RST_REG_CYC  = cyc_min(HOST_RESET_LOW_REG_NS);
   localparam cnt_t HOST_RST_FAST_CYC = cyc_min(HOST_RESET_LOW_FAST_NS);
   localparam cnt_t RECOV_REG_CYC     = cyc_min(RECOVERY_TIME_REG_NS);
   localparam cnt_t RECOV_FAST_CYC    = cyc_min(RECOVERY_TIME_FAST_NS);
   localparam cnt_t PWAIT_REG_CYC     = cyc_min(PRESENCE_WAIT_TIME_REG_NS);
   localparam cnt_t PWAIT_FAST_CYC    = cyc_min(PRESENCE_WAIT_TIME_FAST_NS);
   localparam cnt_t PLOW_REG_CYC      = cyc_min(PRESENCE_LOW_TIME_REG_NS);
   localparam cnt_t PLOW_FAST_CYC     = cyc_min(PRESENCE_LOW_TIME_FAST_NS);
   localparam cnt_t PSMP_REG_CYC      = cyc_min(PRESENCE_SAMPLE_REG_NS);
   localparam cnt_t PSMP_FAST_CYC     = cyc_min(PRESENCE_SAMPLE_FAST_NS);
   localparam cnt_t DLY_REG_CYC       = cyc_min(SLOT_DELAY_REG_NS);
   localparam cnt_t DLY_FAST_CYC      = cyc_min(SLOT_DELAY_FAST_NS);
   localparam cnt_t W1_REG_CYC        = cyc_min(WRITE1_LOW_REG_NS);
   localparam cnt_t W1_FAST_CYC       = cyc_min(WRITE1_LOW_FAST_NS);
   localparam cnt_t W0_REG_CYC        = cyc_min(WRITE0_LOW_REG_NS);
   localparam cnt_t W0_FAST_CYC       = cyc_min(WRITE0_LOW_FAST_NS);
   localparam cnt_t RLOW_REG_CYC      = cyc_min(READ_LOW_REG_NS);
   localparam cnt_t RLOW_FAST_CYC     = cyc_min(READ_LOW_FAST_NS);
   localparam cnt_t RSMP_REG_CYC      = cyc_min(READ_SAMPLE_REG_NS);
   localparam cnt_t RSMP_FAST_CYC     = cyc_min(READ_SAMPLE_FAST_NS);
   localparam cnt_t SLOT_REG_CYC      = cyc_min(SLOT_TIME_REG_NS);
   localparam cnt_t SLOT_FAST_CYC     = cyc_min(SLOT_TIME_FAST_NS);

   // CRC constants, both polynomials in reflected form for lsb-first shifting
   localparam logic [7:0]  CRC8_POLY_REV  = 8'h8c;
   localparam logic [15:0] CRC16_POLY_REV = 16'ha001;
   localparam logic [15:0] CRC16_INIT     = 16'h0000;
   localparam int unsigned ROM_BODY_W     = 56;

   function automatic logic [7:0] crc8_bit(input logic [7:0] c, input logic b);
      return (c[0] ^ b) ? ((c >> 1) ^ CRC8_POLY_REV) : (c >> 1);
   endfunction : crc8_bit

   function automatic logic [15:0] crc16_bit(input logic [15:0] c, input logic b);
      return (c[0] ^ b) ? ((c >> 1) ^ CRC16_POLY_REV) : (c >> 1);
   endfunction : crc16_bit

   // Fixed at elaboration, never at run time
   function automatic logic [7:0] crc8_of(input logic [ROM_BODY_W-1:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < ROM_BODY_W; i++) begin
         c = crc8_bit(c, d[i]);
      end
      return c;
   endfunction : crc8_of

   typedef enum logic [1:0] {
      CMD_RESET = 2'h0,
      CMD_WRITE = 2'h1,
      CMD_READ  = 2'h2
   } host_cmd_t;

endpackage : wire_link_pkg

/* shared/wire_link_if.sv */
// Open-drain single data line between master and device.
// Assumes a pullup: the line is high unless a party drives it low.
`timescale 1ns/1ps
interface wire_link_if;
   logic m_out;
   logic m_oe;
   logic s_out;
   logic s_oe;
   logic line;

   // Wired-and of both drivers with pullup
   assign line = ~((m_oe & ~m_out) | (s_oe & ~s_out));

   modport master (output m_out, output m_oe, input line);
   modport slave  (output s_out, output s_oe, input line);
endinterface : wire_link_if

/* hdl/crc16_unit.sv */
// Bit-serial 16-bit CRC register with clear, direct load and shift.
// Assumes the caller strobes clear or load only between bytes.
`timescale 1ns/1ps
module crc16_unit (
   input  logic        clock_i,
   input  logic        rst_i,
   input  logic        clear_i,
   input  logic        load_i,
   input  logic [15:0] load_val_i,
   input  logic        shift_i,
   input  logic        bit_i,
   output logic [15:0] crc_o
);
   import wire_link_pkg::*;

   logic [15:0] crc_q;

   // Clear wins over load, load over shift
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         crc_q <= CRC16_INIT;
      end else if (clear_i) begin
         crc_q <= CRC16_INIT;
      end else if (load_i) begin
         crc_q <= load_val_i;
      end else if (shift_i) begin
         crc_q <= crc16_bit(crc_q, bit_i);
      end
   end

   assign crc_o = crc_q;
endmodule : crc16_unit

/* hdl/link_slave_end.sv */
// Device end of the single-wire link: reset and presence, slot timing,
// byte transfer and the 16-bit CRC of memory transfers.
// Assumes a memory controller on the user side that decodes commands and
// steers the CRC strobes; line level is synchronous to clock_i.
//
// How it works
// - Reset, presence, write-0, write-1, read slots
// - Regular speed until fast mode set
// - Master reset low at least 480/48 us
// - Presence waits 15-60 or 2-6 us
// - Presence low 60-240 or 8-24 us
// - Reset of 480 us leaves fast mode
// - Short reset in fast mode keeps it
// - Master keeps reset under 960 us
// - Falling edge restarts the slot timer
// - Write slot sampled at timer expiry
// - Read zero held low for timer
// - ROM top byte is CRC8 of body
// - ROM CRC sent true, fixed value
// - CRC16 polynomial, always sent complemented
// - CRC16 sent after each page end
// - First read page: clear, command, address, data
// - Later read pages: clear, page data only
// - Write CRC sent before memory commit
// - First write byte: clear, command, address, data
// - Later write bytes: load address, shift data
// - Written byte echoed after the CRC
`timescale 1ns/1ps
module link_slave_end #(
   parameter wire_link_pkg::cnt_t       RESET_DETECT_CYC = wire_link_pkg::RST_REG_CYC,
   // Arbitrary neutral identity body
   parameter logic [55:0]               ROM_BODY         = 56'h00_0000_0000_a501
) (
   input  logic                         clock_i,
   input  logic                         rst_i,
   wire_link_if.slave                   link,
   input  logic                         fast_set_i,
   output logic                         fast_o,
   output logic                         reset_seen_o,
   output logic [7:0]                   rx_byte_o,
   output logic                         rx_valid_o,
   input  logic [7:0]                   tx_byte_i,
   input  logic                         tx_valid_i,
   output logic                         tx_ready_o,
   input  logic                         crc_clear_i,
   input  logic                         crc_load_i,
   input  logic [15:0]                  crc_load_val_i,
   input  logic                         crc_send_i,
   output logic [15:0]                  crc_o,
   output logic [63:0]                  rom_o
);
   import wire_link_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_PWAIT = 4'b0010,
      ST_PLOW  = 4'b0100,
      ST_BUS   = 4'b1000
   } slave_state_t;

   slave_state_t state_q;
   cnt_t         tmr_q;
   cnt_t         low_cnt_q;
   logic         line_q;
   logic         drv_q;
   logic         slot_q;
   logic         fast_q;
   logic         rst_pulse_q;
   logic         tx_busy_q;
   logic         tx_data_q;
   logic [15:0]  tx_sh_q;
   logic [4:0]   tx_left_q;
   logic [7:0]   rx_sh_q;
   logic [7:0]   rx_byte_q;
   logic [2:0]   rx_cnt_q;
   logic         rx_valid_q;
   logic [15:0]  crc;
   logic         fall_any;
   logic         fall_ext;
   logic         rise;
   logic         long_rst;
   logic         rst_evt;
   logic         slot_end;
   logic         tx_load;
   logic         crc_go;
   logic         crc_shift;
   logic         crc_bit;
   cnt_t         slot_dly;
   cnt_t         pres_wait;
   cnt_t         pres_low;

   assign link.s_out = 1'b0;
   assign link.s_oe  = drv_q;

   assign fall_any = line_q & ~link.line;
   assign fall_ext = fall_any & ~drv_q;
   assign rise     = ~line_q & link.line;

   assign long_rst = low_cnt_q >= RESET_DETECT_CYC;
   assign rst_evt  = rise & (long_rst | (fast_q & (low_cnt_q >= RST_FAST_CYC)));

   assign slot_dly  = by_speed(fast_q, DLY_REG_CYC, DLY_FAST_CYC);
   assign pres_wait = by_speed(fast_q, PWAIT_REG_CYC, PWAIT_FAST_CYC);
   assign pres_low  = by_speed(fast_q, PLOW_REG_CYC, PLOW_FAST_CYC);

   assign slot_end   = (state_q == ST_BUS) & slot_q & (tmr_q == slot_dly - cnt_t'(1));
   assign tx_ready_o = (state_q == ST_BUS) & ~tx_busy_q & ~slot_q;
   assign tx_load    = tx_ready_o & tx_valid_i;
   assign crc_go     = tx_ready_o & crc_send_i;

   // Line history for edge detection
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         line_q <= 1'b1;
      end else begin
         line_q <= link.line;
      end
   end

   // Low width counter, restarted by falls
   // Own drive is not counted, so a long presence is never a reset
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         low_cnt_q <= '0;
      end else if (drv_q) begin
         low_cnt_q <= '0;
      end else if (fall_any) begin
         low_cnt_q <= cnt_t'(1);
      end else if (~link.line && (low_cnt_q != '1)) begin
         low_cnt_q <= low_cnt_q + cnt_t'(1);
      end
   end

   // Speed mode
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         fast_q <= 1'b0;
      end else if (rst_evt && long_rst) begin
         fast_q <= 1'b0;
      end else if (fast_set_i) begin
         fast_q <= 1'b1;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         tmr_q   <= '0;
         slot_q  <= 1'b0;
         drv_q   <= 1'b0;
      end else if (rst_evt) begin
         state_q <= ST_PWAIT;
         tmr_q   <= '0;
         slot_q  <= 1'b0;
         drv_q   <= 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               tmr_q <= '0;
            end
            ST_PWAIT: begin
               if (tmr_q == pres_wait - cnt_t'(1)) begin
                  state_q <= ST_PLOW;
                  tmr_q   <= '0;
                  drv_q   <= 1'b1;
               end else begin
                  tmr_q <= tmr_q + cnt_t'(1);
               end
            end
            ST_PLOW: begin
               if (tmr_q == pres_low - cnt_t'(1)) begin
                  state_q <= ST_BUS;
                  tmr_q   <= '0;
                  drv_q   <= 1'b0;
               end else begin
                  tmr_q <= tmr_q + cnt_t'(1);
               end
            end
            ST_BUS: begin
               if (fall_ext) begin
                  slot_q <= 1'b1;
                  tmr_q  <= '0;
                  drv_q  <= tx_busy_q & ~tx_sh_q[0];
               end else if (slot_end) begin
                  slot_q <= 1'b0;
                  drv_q  <= 1'b0;
               end else if (slot_q) begin
                  tmr_q <= tmr_q + cnt_t'(1);
               end
            end
            default: begin
               state_q <= ST_IDLE;
               drv_q   <= 1'b0;
            end
         endcase
      end
   end

   // Transmit shifter for data bytes and CRC
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         tx_busy_q <= 1'b0;
         tx_data_q <= 1'b0;
         tx_sh_q   <= '0;
         tx_left_q <= '0;
      end else if (rst_evt) begin
         tx_busy_q <= 1'b0;
      end else if (crc_go) begin
         tx_sh_q   <= ~crc;
         tx_left_q <= 5'h10;
         tx_data_q <= 1'b0;
         tx_busy_q <= 1'b1;
      end else if (tx_load) begin
         tx_sh_q   <= {8'h00, tx_byte_i};
         tx_left_q <= 5'h08;
         tx_data_q <= 1'b1;
         tx_busy_q <= 1'b1;
      end else if (slot_end && tx_busy_q) begin
         tx_sh_q   <= {1'b0, tx_sh_q[15:1]};
         tx_left_q <= tx_left_q - 5'h01;
         tx_busy_q <= (tx_left_q != 5'h01);
      end
   end

   // Receive shifter
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rx_sh_q    <= '0;
         rx_byte_q  <= '0;
         rx_cnt_q   <= '0;
         rx_valid_q <= 1'b0;
      end else begin
         rx_valid_q <= 1'b0;
         if (rst_evt || tx_load || crc_go) begin
            rx_cnt_q <= '0;
         end else if (slot_end && !tx_busy_q) begin
            rx_sh_q  <= {link.line, rx_sh_q[7:1]};
            rx_cnt_q <= rx_cnt_q + 3'h1;
            if (rx_cnt_q == 3'h7) begin
               rx_byte_q  <= {link.line, rx_sh_q[7:1]};
               rx_valid_q <= 1'b1;
            end
         end
      end
   end

   // Reset seen pulse
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rst_pulse_q <= 1'b0;
      end else begin
         rst_pulse_q <= rst_evt;
      end
   end

   assign crc_shift = slot_end & (~tx_busy_q | tx_data_q);
   assign crc_bit   = tx_busy_q ? tx_sh_q[0] : link.line;

   // Clear or address load by user
   crc16_unit u_crc (
      .clock_i    (clock_i),
      .rst_i      (rst_i),
      .clear_i    (crc_clear_i),
      .load_i     (crc_load_i),
      .load_val_i (crc_load_val_i),
      .shift_i    (crc_shift),
      .bit_i      (crc_bit),
      .crc_o      (crc)
   );

   assign rom_o = {crc8_of(ROM_BODY), ROM_BODY};

   assign crc_o        = crc;
   assign fast_o       = fast_q;
   assign reset_seen_o = rst_pulse_q;
   assign rx_byte_o    = rx_byte_q;
   assign rx_valid_o   = rx_valid_q;
endmodule : link_slave_end

/* hdl/link_master_end.sv */
// Master end of the single-wire link: reset with presence check and
// byte-wide write and read slots at regular or fast speed.
// Assumes one command at a time from the user side.
`timescale 1ns/1ps
module link_master_end #(
   parameter wire_link_pkg::cnt_t       RESET_LOW_CYC = wire_link_pkg::HOST_RST_REG_CYC,
   parameter wire_link_pkg::cnt_t       RECOVERY_CYC  = wire_link_pkg::RECOV_REG_CYC
) (
   input  logic                         clock_i,
   input  logic                         rst_i,
   wire_link_if.master                  link,
   input  logic                         fast_i,
   input  wire_link_pkg::host_cmd_t     cmd_i,
   input  logic [7:0]                   wr_byte_i,
   input  logic                         cmd_valid_i,
   output logic                         cmd_ready_o,
   output logic                         done_o,
   output logic                         presence_o,
   output logic [7:0]                   rd_byte_o
);
   import wire_link_pkg::*;

   typedef enum logic [4:0] {
      H_IDLE  = 5'b00001,
      H_RLOW  = 5'b00010,
      H_RWAIT = 5'b00100,
      H_SLOW  = 5'b01000,
      H_SREST = 5'b10000
   } host_state_t;

   host_state_t state_q;
   cnt_t        tmr_q;
   logic [2:0]  bit_q;
   logic        done_q;
   logic        spd_q;
   logic        rd_q;
   logic [7:0]  sh_q;
   logic        pres_q;
   logic [7:0]  rd_byte_q;
   logic        take;
   logic        slot_last;
   cnt_t        low_len;
   cnt_t        rst_len;
   cnt_t        rec_len;

   assign cmd_ready_o = (state_q == H_IDLE);
   assign take        = cmd_ready_o & cmd_valid_i;
   assign rst_len = by_speed(spd_q, RESET_LOW_CYC, HOST_RST_FAST_CYC);
   assign rec_len = by_speed(spd_q, RECOVERY_CYC, RECOV_FAST_CYC);
   assign low_len = rd_q  ? by_speed(spd_q, RLOW_REG_CYC, RLOW_FAST_CYC) :
                    sh_q[0] ? by_speed(spd_q, W1_REG_CYC, W1_FAST_CYC) :
                              by_speed(spd_q, W0_REG_CYC, W0_FAST_CYC);
   assign slot_last = (state_q == H_SREST) &
                      (tmr_q == by_speed(spd_q, SLOT_REG_CYC, SLOT_FAST_CYC) - cnt_t'(1));

   // Master drives reset and slot starts
   assign link.m_out = 1'b0;
   assign link.m_oe  = (state_q == H_RLOW) | (state_q == H_SLOW);

   // Sequencing
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= H_IDLE;
         tmr_q   <= '0;
         bit_q   <= '0;
         done_q  <= 1'b0;
      end else begin
         done_q <= 1'b0;
         unique case (state_q)
            H_IDLE: begin
               tmr_q <= '0;
               bit_q <= '0;
               if (take) begin
                  state_q <= (cmd_i == CMD_RESET) ? H_RLOW : H_SLOW;
               end
            end
            H_RLOW: begin
               if (tmr_q == rst_len - cnt_t'(1)) begin
                  state_q <= H_RWAIT;
                  tmr_q   <= '0;
               end else begin
                  tmr_q <= tmr_q + cnt_t'(1);
               end
            end
            H_RWAIT: begin
               if (tmr_q == rec_len - cnt_t'(1)) begin
                  state_q <= H_IDLE;
                  done_q  <= 1'b1;
               end else begin
                  tmr_q <= tmr_q + cnt_t'(1);
               end
            end
            H_SLOW: begin
               tmr_q <= tmr_q + cnt_t'(1);
               if (tmr_q == low_len - cnt_t'(1)) begin
                  state_q <= H_SREST;
               end
            end
            H_SREST: begin
               if (slot_last) begin
                  tmr_q <= '0;
                  bit_q <= bit_q + 3'h1;
                  state_q <= (bit_q == 3'h7) ? H_IDLE : H_SLOW;
                  done_q  <= (bit_q == 3'h7);
               end else begin
                  tmr_q <= tmr_q + cnt_t'(1);
               end
            end
            default: begin
               state_q <= H_IDLE;
            end
         endcase
      end
   end

   // Data path
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         spd_q     <= 1'b0;
         rd_q      <= 1'b0;
         sh_q      <= '0;
         pres_q    <= 1'b0;
         rd_byte_q <= '0;
      end else if (take) begin
         spd_q <= fast_i;
         rd_q  <= (cmd_i == CMD_READ);
         sh_q  <= (cmd_i == CMD_WRITE) ? wr_byte_i : 8'h00;
      end else if ((state_q == H_RWAIT) &&
                   (tmr_q == by_speed(spd_q, PSMP_REG_CYC, PSMP_FAST_CYC))) begin
         pres_q <= ~link.line;
      end else if ((state_q == H_SREST) && rd_q &&
                   (tmr_q == by_speed(spd_q, RSMP_REG_CYC, RSMP_FAST_CYC))) begin
         sh_q <= {link.line, sh_q[7:1]};
      end else if (slot_last) begin
         if (!rd_q) begin
            sh_q <= {1'b0, sh_q[7:1]};
         end
         if (bit_q == 3'h7) begin
            rd_byte_q <= sh_q;
         end
      end
   end

   assign done_o     = done_q;
   assign presence_o = pres_q;
   assign rd_byte_o  = rd_byte_q;
endmodule : link_master_end

/* bench/single_wire_slave_link_crc_checker.sv */
// Checker of the shared line between the two link ends.
// Assumes the interface signals and clock_i as its only domain.
`timescale 1ns/1ps
module single_wire_slave_link_crc_checker #(parameter int RESET_LOW_CYC = 1000) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic m_out,
   input wire logic m_oe,
   input wire logic s_out,
   input wire logic s_oe,
   input wire logic line
);
   logic [12:0] srun_q;
   logic [12:0] mrun_q;
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // Device drive length
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) srun_q <= 13'h0;
      else srun_q <= s_oe ? srun_q + 13'h1 : 13'h0;
   end
   // Master drive length
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) mrun_q <= 13'h0;
      else mrun_q <= m_oe ? mrun_q + 13'h1 : 13'h0;
   end
   a_line_wired_and: assert property (line == ~((m_oe & ~m_out) | (s_oe & ~s_out)))
      else $error("line level wrong");
   a_dev_open_drain: assert property (s_oe |-> !s_out)
      else $error("device drives high");
   a_host_open_drain: assert property (m_oe |-> !m_out)
      else $error("master drives high");
   a_dev_low_width: assert property ($fell(s_oe) |->
      srun_q inside {13'h1e, 13'h12c, 13'h78, 13'h4b0}) else $error("device low width");
   a_host_low_width: assert property ($fell(m_oe) |->
      mrun_q inside {13'ha, 13'h14, 13'h3c, 13'h50, 13'h258, RESET_LOW_CYC})
      else $error("master low width");
   a_presence_wait: assert property ($fell(m_oe) && mrun_q >= 13'h384 |->
      ##[150:600] $rose(s_oe)) else $error("presence wait");
   a_host_recovery: assert property ($fell(m_oe) |-> !m_oe [*8])
      else $error("master recovery");
   a_dev_hold_low: assert property ($rose(s_oe) |-> s_oe [*8])
      else $error("device hold");
   c_fast_zero: cover property ($fell(s_oe) && srun_q == 13'h1e);
   c_presence: cover property ($fell(s_oe) && srun_q == 13'h4b0);
   c_overlap: cover property (s_oe && m_oe);
endmodule : single_wire_slave_link_crc_checker

/* bench/tb_single_wire_slave_link_crc.sv */
// Testbench: both link ends joined by the shared line, user sides driven.
// Assumes the 10 MHz clock and the shortened reset counts set below.
`timescale 1ns/1ps
module tb_single_wire_slave_link_crc;
   import wire_link_pkg::*;
   logic        clock_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        fast_i = 1'b0;
   logic        cmd_valid_i = 1'b0;
   logic [4:0]  op = 5'h0;
   logic [15:0] val = 16'h0;
   host_cmd_t   cmd_i = CMD_RESET;
   logic        fast_o, tx_ready_o, done_o, presence_o;
   logic [7:0]  rx_byte_o, rd_byte_o;
   logic [15:0] crc_o, want;
   logic [63:0] rom_o;
   int          miscompares = 0, comparisons = 0, cycles = 0;
   wire_link_if u_wire_link_if ();
   link_slave_end #(.RESET_DETECT_CYC(13'h320)) u_link_slave_end (.clock_i(clock_i),
      .rst_i(rst_i), .link(u_wire_link_if), .fast_set_i(op[0]), .fast_o(fast_o),
      .reset_seen_o(), .rx_byte_o(rx_byte_o), .rx_valid_o(), .tx_byte_i(val[7:0]),
      .tx_valid_i(op[4]), .tx_ready_o(tx_ready_o), .crc_clear_i(op[1]), .crc_load_i(op[2]),
      .crc_load_val_i(val), .crc_send_i(op[3]), .crc_o(crc_o), .rom_o(rom_o));
   link_master_end #(.RESET_LOW_CYC(13'h3e8), .RECOVERY_CYC(13'h640)) u_link_master_end (
      .clock_i(clock_i), .rst_i(rst_i), .link(u_wire_link_if), .fast_i(fast_i),
      .cmd_i(cmd_i), .wr_byte_i(val[7:0]), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(),
      .done_o(done_o), .presence_o(presence_o), .rd_byte_o(rd_byte_o));
   single_wire_slave_link_crc_checker #(.RESET_LOW_CYC(1000)) u_checker (.clock_i(clock_i),
      .rst_i(rst_i), .m_out(u_wire_link_if.m_out), .m_oe(u_wire_link_if.m_oe),
      .s_out(u_wire_link_if.s_out), .s_oe(u_wire_link_if.s_oe), .line(u_wire_link_if.line));
   always #50 clock_i = ~clock_i;
   task automatic close_out();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : close_out
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         close_out();
      end
   end
   task automatic check(input string what, input logic [15:0] e, input logic [15:0] s);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, e, s);
      end
   endtask : check
   function automatic logic [15:0] fold(input logic [15:0] c, input logic [63:0] d,
                                        input int n, input logic [15:0] p);
      for (int i = 0; i < n; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ p) : (c >> 1);
      return c;
   endfunction : fold
   task automatic dev_op(input logic [4:0] o, input logic [15:0] v);
      op <= o;
      val <= v;
      @(posedge clock_i);
      op <= 5'h0;
   endtask : dev_op
   task automatic run_cmd(input host_cmd_t c, input logic f);
      int n;
      n = 0;
      cmd_i <= c;
      fast_i <= f;
      cmd_valid_i <= 1'b1;
      @(posedge clock_i);
      cmd_valid_i <= 1'b0;
      while (done_o !== 1'b1 && n < 30000) begin
         @(posedge clock_i);
         n++;
      end
   endtask : run_cmd
   task automatic t_reset(input logic f, input logic fast_after);
      run_cmd(CMD_RESET, f);
      check("presence", 16'h1, {15'h0, presence_o});
      check("fast mode", {15'h0, fast_after}, {15'h0, fast_o});
   endtask : t_reset
   task automatic t_write_reg();
      dev_op(5'h02, 16'h00a5);
      run_cmd(CMD_WRITE, 1'b0);
      check("rx byte", 16'h00a5, {8'h0, rx_byte_o});
      check("crc", fold(16'h0, 64'ha5, 8, 16'ha001), crc_o);
      check("rom crc", fold(16'h0, rom_o, 56, 16'h8c), {8'h0, rom_o[63:56]});
   endtask : t_write_reg
   task automatic t_fast_read();
      dev_op(5'h02, 16'h003c);
      run_cmd(CMD_WRITE, 1'b1);
      want = fold(16'h0, 64'h963c, 16, 16'ha001);
      dev_op(5'h10, 16'h0096);
      run_cmd(CMD_READ, 1'b1);
      check("rd byte", 16'h0096, {8'h0, rd_byte_o});
      check("crc", want, crc_o);
      dev_op(5'h08, 16'h0);
      run_cmd(CMD_READ, 1'b1);
      check("crc low", {8'h0, ~want[7:0]}, {8'h0, rd_byte_o});
      run_cmd(CMD_READ, 1'b1);
      check("crc high", {8'h0, ~want[15:8]}, {8'h0, rd_byte_o});
   endtask : t_fast_read
   task automatic t_load();
      dev_op(5'h04, 16'h0009);
      run_cmd(CMD_WRITE, 1'b1);
      check("crc", fold(16'h0009, 64'h09, 8, 16'ha001), crc_o);
      dev_op(5'h10, 16'h0009);
      run_cmd(CMD_READ, 1'b1);
      check("echo", 16'h0009, {8'h0, rd_byte_o});
   endtask : t_load
   initial begin
      repeat (8) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      t_reset(1'b0, 1'b0);
      t_write_reg();
      dev_op(5'h01, 16'h0);
      t_reset(1'b1, 1'b1);
      t_fast_read();
      t_load();
      t_reset(1'b0, 1'b0);
      close_out();
   end
endmodule : tb_single_wire_slave_link_crc
